// ===== design/rio_pkg.sv
// Constants shared by both ends of the ranked interrupt and I/O strobe link
// Summary of operation
// - Up to 25 channels, lowest number wins.
// - Five standard channels with fixed device roles.
// - Serviced channel word gated into instruction register.
// - Each channel supplies its own changeable word.
// - Service word leaves location counter; program resumes.
// - Service fetch cycle lasts one microsecond.
// - Immediate first execute after a service fetch stretched to two microseconds.
// - Repeating channel keeps lower channels waiting.
// - Subroutine service locks lower channels until return.
// - Higher channel preempts; nested services tracked.
// - Freeze blocks service; unfreeze releases it.
// - Requests during freeze held, served after unfreeze.
// - Peripheral operation first execute held four microseconds.
// - Strobe 1.5 microseconds wide during first execute.
// - Peripheral splits address into device and command.
// - Raised event adds skip cycle, else none.
// - Serviced channel presents full 30-bit word.
package rio_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CHAN_N   = 25;
    localparam int unsigned CHAN_W   = 5;
    localparam int unsigned WORD_W   = 30;
    localparam int unsigned ADDR_W   = 15;
    localparam int unsigned DEVSEL_W = 6;
    localparam int unsigned CMD_W    = 9;
    localparam int unsigned CNT_W    = 8;

    // ------------------------------------------------------------
    // Field positions of the peripheral operation address
    // ------------------------------------------------------------
    localparam int unsigned CMD_LSB    = 0;
    localparam int unsigned DEVSEL_LSB = 9;

    // ------------------------------------------------------------
    // Standard channel assignment
    // ------------------------------------------------------------
    localparam logic [4:0] CH_PEN_PULSE = 5'h00;
    localparam logic [4:0] CH_TYPER     = 5'h01;
    localparam logic [4:0] CH_COMMS     = 5'h02;
    localparam logic [4:0] CH_FRAME_CLK = 5'h03;
    localparam logic [4:0] CH_VECTOR    = 5'h04;

    // ------------------------------------------------------------
    // Timing, in ns, and the derived cycle counts at 40 MHz
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS      = 25;
    localparam int unsigned FETCH_NS    = 1000;
    localparam int unsigned IMM_NS      = 1000;
    localparam int unsigned IMM_SVC_NS  = 2000;
    localparam int unsigned STROBE_NS   = 1500;
    localparam int unsigned PIO_EXEC_NS = 4000;
    localparam int unsigned SKIP_NS     = 2000;

    localparam logic [7:0] FETCH_CYC    = 8'((FETCH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] IMM_CYC      = 8'((IMM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] IMM_SVC_CYC  = 8'((IMM_SVC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] STROBE_CYC   = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] PIO_EXEC_CYC = 8'((PIO_EXEC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SKIP_CYC     = 8'((SKIP_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        FROZEN_RST = 1'b0;
    localparam logic [24:0] INSVC_RST  = 25'h000_0000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        RIO_IDLE   = 5'b00001,
        RIO_SFETCH = 5'b00010,
        RIO_IMM    = 5'b00100,
        RIO_PIO    = 5'b01000,
        RIO_SKIP   = 5'b10000
    } rio_state_t;

endpackage

// ===== design/rio_link_if.sv
// Link between the processor sequencer and the peripheral interfaces
`timescale 1ns/10ps
`default_nettype none
interface rio_link_if;
    logic [24:0] svc_req;
    logic        svc_gate;
    logic [4:0]  svc_chan;
    logic [29:0] external_instruction_source;
    logic        pio_strobe;
    logic [14:0] xfer_bus;
    logic        pio_event;

    modport dev (
        input  svc_req,
        output svc_gate,
        output svc_chan,
        input  external_instruction_source,
        output pio_strobe,
        output xfer_bus,
        input  pio_event
    );

    modport per (
        output svc_req,
        input  svc_gate,
        input  svc_chan,
        output external_instruction_source,
        input  pio_strobe,
        input  xfer_bus,
        output pio_event
    );
endinterface
`default_nettype wire

// ===== design/rio_rank_pick.sv
// Lowest-numbered-first picker over the channel vector
`timescale 1ns/10ps
`default_nettype none
module rio_rank_pick (
    // Candidates
    input  wire logic [24:0] req_i,
    // Result
    output logic             hit_o,
    output logic [4:0]       idx_o,
    output logic [24:0]      first_o,
    output logic [24:0]      incl_o
);
    logic [25:0] seen;

    assign seen[0] = 1'b0;

    genvar c;
    generate
        for (c = 0; c < 25; c++)
        begin : g_rank
            assign seen[c+1]  = seen[c] | req_i[c];
            assign first_o[c] = req_i[c] & ~seen[c];
            assign incl_o[c]  = seen[c+1];
        end
    endgenerate

    assign hit_o = seen[25];

    always_comb
    begin
        idx_o = 5'h00;
        for (int i = 0; i < 25; i++)
        begin
            if (first_o[i])
            begin
                idx_o = 5'(i);
            end
        end
    end
endmodule // rio_rank_pick
`default_nettype wire

// ===== design/rio_cpu_end.sv
// Processor end: ranked service fetch, nesting, freeze and peripheral strobe timing
`timescale 1ns/10ps
`default_nettype none
module rio_cpu_end (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Link to the peripheral interfaces
    rio_link_if.dev          link,
    // Instruction sequencing from the core
    input  wire logic        boundary_i,
    input  wire logic        imm_exec_i,
    input  wire logic        pio_start_i,
    input  wire logic [14:0] pio_addr_i,
    input  wire logic        jsr_done_i,
    input  wire logic        ret_done_i,
    input  wire logic        freeze_i,
    input  wire logic        unfreeze_i,
    // Answers to the core
    output logic             mem_fetch_o,
    output logic             instr_valid_o,
    output logic [29:0]      instruction_holding_reg_o,
    output logic             from_service_o,
    output logic             exec_done_o,
    output logic             lc_skip_o,
    output logic             frozen_o,
    output logic [24:0]      in_service_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rio_pkg::rio_state_t state;
    rio_pkg::rio_state_t next_state;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [7:0]  imm_limit;
    logic [4:0]  svc_chan;
    logic [14:0] pio_addr;
    logic        ev_seen;
    logic        frozen;
    logic        from_service;
    logic [24:0] in_service;
    logic        next_frozen;
    logic        next_from_service;
    logic [24:0] next_in_service;

    logic [24:0] eligible;
    logic [24:0] allowed;
    logic        grant_hit;
    logic [4:0]  grant_idx;
    logic        ins_hit;
    logic [24:0] ins_first;
    logic [24:0] ins_incl;

    logic        st_idle;
    logic        st_sfetch;
    logic        st_imm;
    logic        st_pio;
    logic        st_skip;
    logic        cnt_end;
    logic        take_svc;
    logic        take_mem;
    logic        sfetch_end;
    logic        imm_end;
    logic        pio_end;
    logic        skip_end;
    logic        svc_jsr;

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    assign allowed  = ~ins_incl;
    assign eligible = link.svc_req & allowed & {25{~frozen}};

    rio_rank_pick u_grant (
        .req_i   (eligible),
        .hit_o   (grant_hit),
        .idx_o   (grant_idx),
        .first_o (),
        .incl_o  ()
    );

    rio_rank_pick u_nest (
        .req_i   (in_service),
        .hit_o   (ins_hit),
        .idx_o   (),
        .first_o (ins_first),
        .incl_o  (ins_incl)
    );

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    assign st_idle    = (state == rio_pkg::RIO_IDLE);
    assign st_sfetch  = (state == rio_pkg::RIO_SFETCH);
    assign st_imm     = (state == rio_pkg::RIO_IMM);
    assign st_pio     = (state == rio_pkg::RIO_PIO);
    assign st_skip    = (state == rio_pkg::RIO_SKIP);

    assign imm_limit  = from_service ? rio_pkg::IMM_SVC_CYC : rio_pkg::IMM_CYC;
    assign take_svc   = st_idle & boundary_i & grant_hit;
    assign take_mem   = st_idle & boundary_i & ~grant_hit;
    assign sfetch_end = st_sfetch & (cnt == rio_pkg::FETCH_CYC - 8'h01);
    assign imm_end    = st_imm & (cnt == imm_limit - 8'h01);
    assign pio_end    = st_pio & (cnt == rio_pkg::PIO_EXEC_CYC - 8'h01);
    assign skip_end   = st_skip & (cnt == rio_pkg::SKIP_CYC - 8'h01);
    assign cnt_end    = sfetch_end | imm_end | pio_end | skip_end;
    assign svc_jsr    = jsr_done_i & from_service;

    // ------------------------------------------------------------
    // Link outputs
    // ------------------------------------------------------------
    assign link.svc_gate   = st_sfetch;
    assign link.svc_chan   = svc_chan;
    assign link.pio_strobe = st_pio & (cnt < rio_pkg::STROBE_CYC);
    assign link.xfer_bus   = pio_addr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt + 8'h01;
        unique case (state)
            rio_pkg::RIO_IDLE:
            begin
                next_cnt = 8'h00;
                if (take_svc)
                begin
                    next_state = rio_pkg::RIO_SFETCH;
                end
                else if (imm_exec_i)
                begin
                    next_state = rio_pkg::RIO_IMM;
                end
                else if (pio_start_i)
                begin
                    next_state = rio_pkg::RIO_PIO;
                end
            end
            rio_pkg::RIO_SFETCH, rio_pkg::RIO_IMM, rio_pkg::RIO_SKIP:
            begin
                if (cnt_end)
                begin
                    next_state = rio_pkg::RIO_IDLE;
                    next_cnt   = 8'h00;
                end
            end
            rio_pkg::RIO_PIO:
            begin
                if (pio_end)
                begin
                    next_state = (ev_seen | link.pio_event) ? rio_pkg::RIO_SKIP
                                                            : rio_pkg::RIO_IDLE;
                    next_cnt   = 8'h00;
                end
            end
            default:
            begin
                next_state = rio_pkg::RIO_IDLE;
                next_cnt   = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state <= rio_pkg::RIO_IDLE;
            cnt   <= 8'h00;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            svc_chan <= 5'h00;
            pio_addr <= 15'h0000;
            ev_seen  <= 1'b0;
        end
        else
        begin
            if (take_svc)
            begin
                svc_chan <= grant_idx;
            end
            if (st_idle & ~take_svc & ~imm_exec_i & pio_start_i)
            begin
                pio_addr <= pio_addr_i;
                ev_seen  <= 1'b0;
            end
            else if (st_pio & link.pio_event)
            begin
                ev_seen <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Service bookkeeping
    // ------------------------------------------------------------
    assign next_frozen       = freeze_i | (frozen & ~unfreeze_i);
    // The service word runs instead of a memory word, so the core holds its counter
    assign next_from_service = sfetch_end | (from_service & ~take_mem);
    // Return closes the innermost service, which is always the lowest set bit
    assign next_in_service   = svc_jsr ? (in_service | (25'h000_0001 << svc_chan))
                             : (ret_done_i & ins_hit) ? (in_service & ~ins_first)
                             : in_service;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            frozen       <= rio_pkg::FROZEN_RST;
            from_service <= 1'b0;
            in_service   <= rio_pkg::INSVC_RST;
        end
        else
        begin
            frozen       <= next_frozen;
            from_service <= next_from_service;
            in_service   <= next_in_service;
        end
    end

    // ------------------------------------------------------------
    // Answers to the core
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mem_fetch_o               <= 1'b0;
            instr_valid_o             <= 1'b0;
            instruction_holding_reg_o <= 30'h0000_0000;
            exec_done_o               <= 1'b0;
            lc_skip_o                 <= 1'b0;
        end
        else
        begin
            mem_fetch_o   <= take_mem;
            instr_valid_o <= sfetch_end;
            exec_done_o   <= imm_end | skip_end | (pio_end & ~(ev_seen | link.pio_event));
            lc_skip_o     <= skip_end;
            if (sfetch_end)
            begin
                instruction_holding_reg_o <= link.external_instruction_source;
            end
        end
    end

    assign from_service_o = from_service;
    assign frozen_o       = frozen;
    assign in_service_o   = in_service;

endmodule // rio_cpu_end
`default_nettype wire

// ===== design/rio_periph_end.sv
// Peripheral end: request latches, per-channel service words, strobe decode
`timescale 1ns/10ps
`default_nettype none
module rio_periph_end (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Link to the processor
    rio_link_if.per          link,
    // Device side
    input  wire logic [24:0] raise_i,
    input  wire logic        word_wr_i,
    input  wire logic [4:0]  word_chan_i,
    input  wire logic [29:0] word_data_i,
    input  wire logic        event_i,
    output logic [24:0]      pending_o,
    output logic             cmd_valid_o,
    output logic [5:0]       dev_sel_o,
    output logic [8:0]       cmd_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [29:0] svc_word [0:24];
    logic [24:0] pend;
    logic [24:0] served;
    logic        gate_q;
    logic        strobe_q;
    logic [29:0] src_q;
    logic        event_q;
    logic        gate_fall;
    logic        strobe_rise;

    assign gate_fall   = gate_q & ~link.svc_gate;
    assign strobe_rise = link.pio_strobe & ~strobe_q;

    // ------------------------------------------------------------
    // Request latches; a new raise beats the clear
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 25; c++)
        begin : g_chan
            assign served[c] = gate_fall & (link.svc_chan == 5'(c));
            always_ff @(posedge clk_sys_i)
            begin
                if (sys_rst_i)
                begin
                    pend[c] <= 1'b0;
                end
                else
                begin
                    pend[c] <= raise_i[c] | (pend[c] & ~served[c]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Service words; only the gated channel drives the source
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (word_wr_i & (word_chan_i < 5'(rio_pkg::CHAN_N)))
        begin
            svc_word[word_chan_i] <= word_data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            gate_q   <= 1'b0;
            strobe_q <= 1'b0;
            src_q    <= 30'h0000_0000;
            event_q  <= 1'b0;
        end
        else
        begin
            gate_q   <= link.svc_gate;
            strobe_q <= link.pio_strobe;
            event_q  <= event_i;
            if (link.svc_gate & (link.svc_chan < 5'(rio_pkg::CHAN_N)))
            begin
                src_q <= svc_word[link.svc_chan];
            end
            else
            begin
                src_q <= 30'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            cmd_valid_o <= 1'b0;
            dev_sel_o   <= 6'h00;
            cmd_o       <= 9'h000;
        end
        else
        begin
            cmd_valid_o <= strobe_rise;
            if (strobe_rise)
            begin
                dev_sel_o <= link.xfer_bus[rio_pkg::DEVSEL_LSB +: 6];
                cmd_o     <= link.xfer_bus[rio_pkg::CMD_LSB +: 9];
            end
        end
    end

    assign link.svc_req                     = pend;
    assign link.external_instruction_source = src_q;
    assign link.pio_event                   = event_q;
    assign pending_o                        = pend;

endmodule // rio_periph_end
`default_nettype wire

// ===== dv/rio_link_checker.sv
// Assertions on the service fetch and strobe link
`timescale 1ns/10ps
`default_nettype none
module rio_link_checker (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    // Link
    input wire logic [24:0] svc_req,
    input wire logic        svc_gate,
    input wire logic [4:0]  svc_chan,
    input wire logic [29:0] external_instruction_source,
    input wire logic        pio_strobe,
    input wire logic [14:0] xfer_bus,
    input wire logic        pio_event
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // Cycles spent high so far
    logic      [7:0]  gate_n;
    logic      [7:0]  strb_n;
    wire logic [24:0] sel = 25'h1 << svc_chan;
    always_ff @(posedge clk_sys_i)
    begin
        gate_n <= svc_gate ? gate_n + 8'h1 : 8'h0;
        strb_n <= pio_strobe ? strb_n + 8'h1 : 8'h0;
    end
    a_gate_len: assert property ($fell(svc_gate) |-> gate_n == 8'h28)
        else $error("fetch gate length wrong");
    a_gate_max: assert property (svc_gate |-> gate_n < 8'h28)
        else $error("fetch gate too long");
    a_strobe_len: assert property ($fell(pio_strobe) |-> strb_n == 8'h3C)
        else $error("strobe length wrong");
    a_strobe_max: assert property (pio_strobe |-> strb_n < 8'h3C)
        else $error("strobe too long");
    a_pick_first: assert property ($rose(svc_gate) |->
        ($past(svc_req) & sel) != 0 && ($past(svc_req) & (sel - 25'h1)) == 0)
        else $error("wrong channel picked");
    a_chan_hold: assert property (svc_gate && $past(svc_gate) |-> $stable(svc_chan))
        else $error("channel moved in fetch");
    a_word_idle: assert property (!$past(svc_gate) |-> external_instruction_source == 30'h0)
        else $error("word driven outside fetch");
    a_req_clear: assert property ($fell(svc_gate) |=> !svc_req[$past(svc_chan, 2)])
        else $error("request not cleared");
    a_bus_hold: assert property (pio_strobe && $past(pio_strobe) |-> $stable(xfer_bus))
        else $error("bus moved in strobe");
    c_fetch: cover property ($rose(svc_gate));
    c_strobe: cover property ($rose(pio_strobe));
    c_event: cover property (pio_strobe && pio_event);
endmodule // rio_link_checker
`default_nettype wire

// ===== dv/ranked_interrupt_and_io_strobe_tb.sv
// Bench joining the processor end to the peripheral end
`timescale 1ns/10ps
`default_nettype none
module ranked_interrupt_and_io_strobe_tb;
    logic        clk_sys_i;
    logic        sys_rst_i;
    logic        bnd, imm, pst, jsr, ret, frz, ufz, wwr, evt;
    logic [14:0] paddr;
    logic [24:0] rse;
    logic [4:0]  wch;
    logic [29:0] wdt;
    logic        mfetch, ivld, fsvc, xdone, skip, frozen, cvld;
    logic [29:0] hreg;
    logic [24:0] insvc, pend;
    logic [5:0]  dsel;
    logic [8:0]  cmd;
    logic [14:0] adr [4] = '{15'h7FFF, 15'h0000, 15'h2A55, 15'h55AA};
    int          bad_count, check_count, cyc, n, strb_cnt;
    rio_link_if link_if ();
    rio_cpu_end u_rio_cpu_end (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link_if),
        .boundary_i(bnd), .imm_exec_i(imm), .pio_start_i(pst), .pio_addr_i(paddr), .jsr_done_i(jsr),
        .ret_done_i(ret), .freeze_i(frz), .unfreeze_i(ufz), .mem_fetch_o(mfetch), .instr_valid_o(ivld),
        .instruction_holding_reg_o(hreg), .from_service_o(fsvc), .exec_done_o(xdone), .lc_skip_o(skip),
        .frozen_o(frozen), .in_service_o(insvc));
    rio_periph_end u_rio_periph_end (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link_if),
        .raise_i(rse), .word_wr_i(wwr), .word_chan_i(wch), .word_data_i(wdt), .event_i(evt),
        .pending_o(pend), .cmd_valid_o(cvld), .dev_sel_o(dsel), .cmd_o(cmd));
    rio_link_checker u_rio_link_checker (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .svc_req(link_if.svc_req), .svc_gate(link_if.svc_gate), .svc_chan(link_if.svc_chan),
        .external_instruction_source(link_if.external_instruction_source),
        .pio_strobe(link_if.pio_strobe), .xfer_bus(link_if.xfer_bus), .pio_event(link_if.pio_event));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cvld === 1'b1)
            strb_cnt <= strb_cnt + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            results();
        end
    end
    function automatic logic [29:0] wd(input logic [4:0] c);
        return {c, 25'h155_5555};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks=%0d errors=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Raise requests, subroutine marks, freeze controls, word writes
    task pulse(input int k, input logic [24:0] m);
        @(posedge clk_sys_i);
        case (k)
            0: rse <= m;
            1: jsr <= 1'b1;
            2: ret <= 1'b1;
            3: frz <= 1'b1;
            4: ufz <= 1'b1;
            default:
            begin
                wwr <= 1'b1;
                wch <= m[4:0];
                wdt <= wd(m[4:0]);
            end
        endcase
        @(posedge clk_sys_i);
        {rse, jsr, ret, frz, ufz, wwr} <= '0;
        #1;
    endtask
    // Start a boundary, immediate or peripheral op and count cycles to the answer
    task go(input int k, input logic [14:0] a);
        @(posedge clk_sys_i);
        case (k)
            0: bnd <= 1'b1;
            1: imm <= 1'b1;
            default:
            begin
                pst <= 1'b1;
                paddr <= a;
            end
        endcase
        @(posedge clk_sys_i);
        {bnd, imm, pst} <= '0;
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end
        while ((ivld | xdone | mfetch) !== 1'b1 && n < 400);
    endtask
    task svc(input logic [4:0] c);
        go(0, '0);
        chk(n, 41);
        chk(hreg, wd(c));
        chk(fsvc, 1);
    endtask
    initial
    begin
        {bnd, imm, pst, jsr, ret, frz, ufz, wwr, evt} = '0;
        {paddr, rse, wch, wdt} = '0;
        {bad_count, check_count, cyc, strb_cnt} = '0;
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1;
        chk({frozen, insvc}, 0);
        go(0, '0);
        chk(n, 1);
        for (int c = 0; c < 25; c++) pulse(5, 25'(c));
        pulse(0, 25'h000_0015);
        for (int c = 0; c < 5; c += 2) svc(5'(c));
        go(1, '0);
        chk(n, 81);
        pulse(0, 25'h100_0000);
        svc(5'd24);
        go(0, '0);
        go(1, '0);
        chk(n, 41);
        chk(fsvc, 0);
        pulse(0, 25'h000_0003);
        svc(5'd0);
        pulse(0, 25'h000_0001);
        svc(5'd0);
        svc(5'd1);
        pulse(0, 25'h000_0008);
        svc(5'd3);
        pulse(1, '0);
        chk(insvc, 25'h000_0008);
        pulse(0, 25'h000_0012);
        svc(5'd1);
        pulse(1, '0);
        chk(insvc, 25'h000_000A);
        pulse(2, '0);
        chk(insvc, 25'h000_0008);
        go(0, '0);
        chk(n, 1);
        chk(pend, 25'h000_0010);
        pulse(2, '0);
        svc(rio_pkg::CH_VECTOR);
        pulse(3, '0);
        chk(frozen, 1);
        pulse(0, 25'h000_0004);
        go(0, '0);
        chk(n, 1);
        chk(pend, 25'h000_0004);
        pulse(4, '0);
        svc(5'd2);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys_i);
            evt <= k[0];
            go(2, adr[k]);
            chk(n, k[0] ? 241 : 161);
            chk(skip, k[0]);
            chk({dsel, cmd}, adr[k]);
        end
        chk(strb_cnt, 4);
        results();
    end
endmodule // ranked_interrupt_and_io_strobe_tb
`default_nettype wire
